/* rtl/ioxc_top.sv */
`timescale 1ns/1ns
module ioxc_top (
  input wire logic pclk, // System clock, 25 MHz
  input wire logic presetn, // Ordinary reset, active low
  input wire logic cold_rst_n, // Fundamental reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic [3:0][15:0] core_out, // Core output values per slot
  input wire logic bit_clk, // Link bit clock
  input wire logic sda_i, // Data line level
  output logic sda_oe_n, // Data pull-down, low drives
  output logic scl_oe_n, // Clock pull-down, low drives
  output logic irq // Interrupt, high active
);
  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Lowest pending slot and its valid flag
  function automatic logic [2:0] pick(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : pick

  // Select code to slot, top bit flags a legal code
  function automatic logic [2:0] sel2slot(input logic [3:0] s);
    logic [2:0] r;
    unique case (s)
      ioxc_pkg::SEL_E0: r = 3'b100;
      ioxc_pkg::SEL_E1: r = 3'b101;
      ioxc_pkg::SEL_E2: r = 3'b110;
      ioxc_pkg::SEL_E4: r = {1'b1, ioxc_pkg::SLOT_E4};
      default: r = 3'b000;
    endcase
    return r;
  endfunction : sel2slot

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic tm_reg; // Test mode
  logic [3:0] sel_reg; // Expander select
  logic done_reg; // Completion flag
  logic [15:0] test_data_reg; // Software output values
  logic [6:0] ea_reg [3]; // Sticky bus addresses
  logic [15:0] in_img_reg [4]; // Last input values read
  logic [15:0] sent_img_reg [4]; // Last output values sent
  logic [3:0] pend_init_reg; // Init sequences waiting
  logic [3:0] pend_out_reg; // Output updates waiting
  logic [3:0] sw_out_reg; // Output update asked by software
  logic [3:0] pend_rfr_reg; // Refreshes waiting
  logic act_reg; // Transaction launched, not done
  logic [1:0] cur_slot_reg; // Slot in flight
  ioxc_pkg::ioxc_kind_t cur_kind_reg; // Kind in flight
  logic cur_sw_reg; // In-flight op counts for done
  logic [ioxc_pkg::EV_W-1:0] istat_reg; // Sticky events
  logic [ioxc_pkg::EV_W-1:0] imask_reg; // Event enables
  ioxc_pkg::ioxc_req_t req_reg; // Engine request
  ioxc_pkg::ioxc_rsp_t rsp; // Engine answer
  logic eng_busy; // Engine frame running
  logic [2:0] sel_slot; // Selected slot, valid on top
  logic [15:0] want [4]; // Output values to supply
  logic [2:0] nxt_init, nxt_out, nxt_rfr; // Scheduler picks
  logic wr_fire, rd_fire, setup; // APB phases
  logic hit_ctl, hit_addr, hit_stat, hit_mask; // Decodes
  logic set_done; // Completion for the selected slot
  logic [ioxc_pkg::EV_W-1:0] ev; // Events this cycle

  assign setup = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign hit_ctl = (paddr == ioxc_pkg::CTL_OFS);
  assign hit_addr = (paddr == ioxc_pkg::ADDR0_OFS);
  assign hit_stat = (paddr == ioxc_pkg::ISTAT_OFS);
  assign hit_mask = (paddr == ioxc_pkg::IMASK_OFS);
  assign sel_slot = sel2slot(sel_reg);
  assign nxt_init = pick(pend_init_reg);
  assign nxt_out = pick(pend_out_reg);
  assign nxt_rfr = pick(pend_rfr_reg);

  ////////////////////////////////////////////////////////////////////////
  // Output values per slot
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      want[i] = core_out[i];
      if (tm_reg && sel_slot[2] && sel_slot[1:0] == 2'(i)) begin
        want[i] = test_data_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_reg <= 1'b0;
      sel_reg <= ioxc_pkg::SEL_E0;
      test_data_reg <= 16'h0000;
    end else if (wr_fire && hit_ctl) begin
      tm_reg <= pwdata[ioxc_pkg::TM_BIT];
      sel_reg <= pwdata[ioxc_pkg::SEL_LSB +: 4];
      // only output bits, only in test mode
      if (pwdata[ioxc_pkg::TM_BIT]) begin
        test_data_reg <= (test_data_reg & ioxc_pkg::INPUT_MASK) |
          (pwdata[ioxc_pkg::DATA_LSB +: 16] & ~ioxc_pkg::INPUT_MASK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky bus addresses, fundamental reset only
  always_ff @(posedge pclk or negedge cold_rst_n) begin
    if (!cold_rst_n) begin
      ea_reg[0] <= 7'h00;
      ea_reg[1] <= 7'h00;
      ea_reg[2] <= 7'h00;
    end else if (wr_fire && hit_addr) begin
      ea_reg[0] <= pwdata[ioxc_pkg::ADDR0_LSB +: 7];
      ea_reg[1] <= pwdata[ioxc_pkg::ADDR1_LSB +: 7];
      ea_reg[2] <= pwdata[ioxc_pkg::ADDR2_LSB +: 7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending work; a new request wins over the launch clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_init_reg <= 4'h0;
      pend_out_reg <= 4'h0;
      sw_out_reg <= 4'h0;
      pend_rfr_reg <= 4'h0;
    end else begin
      if (req_reg.start) begin
        unique case (req_reg.kind)
          ioxc_pkg::K_INIT: pend_init_reg[cur_slot_reg] <= 1'b0;
          ioxc_pkg::K_OUT: begin
            pend_out_reg[cur_slot_reg] <= 1'b0;
            sw_out_reg[cur_slot_reg] <= 1'b0;
          end
          default: pend_rfr_reg[cur_slot_reg] <= 1'b0;
        endcase
      end
      // Core changes trigger an update of their own
      for (int i = 0; i < 4; i++) begin
        if (want[i] != sent_img_reg[i] && !act_reg) begin
          pend_out_reg[i] <= 1'b1;
        end
      end
      if (wr_fire && hit_addr) begin
        pend_init_reg[2:0] <= 3'b111;
      end
      if (wr_fire && hit_ctl) begin
        if (pwdata[ioxc_pkg::RFR_BIT]) begin
          pend_rfr_reg <= 4'hF;
        end
        if (pwdata[ioxc_pkg::TM_BIT]) begin
          if (sel2slot(pwdata[ioxc_pkg::SEL_LSB +: 4]) != 3'b000) begin
            pend_out_reg[sel2slot(pwdata[ioxc_pkg::SEL_LSB +: 4])
                         [1:0]] <= 1'b1;
            sw_out_reg[sel2slot(pwdata[ioxc_pkg::SEL_LSB +: 4])
                       [1:0]] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scheduler: init before output before refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= 1'b0;
      cur_slot_reg <= 2'h0;
      cur_kind_reg <= ioxc_pkg::K_INIT;
      cur_sw_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      req_reg.start <= 1'b0;
      if (act_reg) begin
        if (rsp.done) begin
          act_reg <= 1'b0;
        end
      end else if (nxt_init[2] || nxt_out[2] || nxt_rfr[2]) begin
        act_reg <= 1'b1;
        req_reg.start <= 1'b1;
        if (nxt_init[2]) begin
          cur_slot_reg <= nxt_init[1:0];
          cur_kind_reg <= ioxc_pkg::K_INIT;
          cur_sw_reg <= 1'b1;
          req_reg.kind <= ioxc_pkg::K_INIT;
          req_reg.wdata <= ioxc_pkg::INPUT_MASK;
        end else if (nxt_out[2]) begin
          cur_slot_reg <= nxt_out[1:0];
          cur_kind_reg <= ioxc_pkg::K_OUT;
          cur_sw_reg <= sw_out_reg[nxt_out[1:0]];
          req_reg.kind <= ioxc_pkg::K_OUT;
          req_reg.wdata <= want[nxt_out[1:0]];
        end else begin
          cur_slot_reg <= nxt_rfr[1:0];
          cur_kind_reg <= ioxc_pkg::K_RFR;
          cur_sw_reg <= 1'b1;
          req_reg.kind <= ioxc_pkg::K_RFR;
          req_reg.wdata <= want[nxt_rfr[1:0]];
        end
        req_reg.addr <= ioxc_pkg::E4_ADDR;
        for (int i = 0; i < 3; i++) begin
          if (pick(pend_init_reg | ({4{~nxt_init[2]}} &
              (pend_out_reg | ({4{~nxt_out[2]}} & pend_rfr_reg))))
              == {1'b1, 2'(i)}) begin
            req_reg.addr <= ea_reg[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sent image updated when an output or refresh frame starts, input image when a refresh frame ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        in_img_reg[i] <= 16'h0000;
        sent_img_reg[i] <= 16'h0000;
      end
    end else begin
      if (req_reg.start && cur_kind_reg != ioxc_pkg::K_INIT) begin
        sent_img_reg[cur_slot_reg] <= req_reg.wdata;
      end
      if (rsp.done && cur_kind_reg == ioxc_pkg::K_RFR) begin
        in_img_reg[cur_slot_reg] <= rsp.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion flag; set wins over the clear
  // done for the selected slot only
  assign set_done = rsp.done && cur_sw_reg && sel_slot[2] &&
                    sel_slot[1:0] == cur_slot_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (set_done) begin
      done_reg <= 1'b1;
    end else if (wr_fire && hit_ctl && pwdata[ioxc_pkg::DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, read clears, set wins
  always_comb begin
    ev = '0;
    ev[ioxc_pkg::EV_DONE] = set_done;
    ev[ioxc_pkg::EV_INIT] = rsp.done && cur_kind_reg == ioxc_pkg::K_INIT;
    ev[ioxc_pkg::EV_RFR] = rsp.done && cur_kind_reg == ioxc_pkg::K_RFR;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= '0;
      imask_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (rd_fire && hit_stat) begin
        istat_reg <= ev;
      end else begin
        istat_reg <= istat_reg | ev;
      end
      if (wr_fire && hit_mask) begin
        imask_reg <= pwdata[ioxc_pkg::EV_W-1:0];
      end
      irq <= |(istat_reg & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~(hit_ctl | hit_addr | hit_stat | hit_mask);
      prdata <= 32'h00000000;
      if (setup && !pwrite) begin
        if (hit_ctl) begin
          // inputs from image, outputs as supplied
          prdata[ioxc_pkg::DATA_LSB +: 16] <= sel_slot[2] ?
            ((in_img_reg[sel_slot[1:0]] & ioxc_pkg::INPUT_MASK) |
             (want[sel_slot[1:0]] & ~ioxc_pkg::INPUT_MASK)) : 16'h0000;
          prdata[ioxc_pkg::TM_BIT] <= tm_reg;
          prdata[ioxc_pkg::SEL_LSB +: 4] <= sel_reg;
          prdata[ioxc_pkg::DONE_BIT] <= done_reg;
        end else if (hit_addr) begin
          prdata[ioxc_pkg::ADDR0_LSB +: 7] <= ea_reg[0];
          prdata[ioxc_pkg::ADDR1_LSB +: 7] <= ea_reg[1];
          prdata[ioxc_pkg::ADDR2_LSB +: 7] <= ea_reg[2];
        end else if (hit_stat) begin
          prdata[ioxc_pkg::EV_W-1:0] <= istat_reg;
        end else if (hit_mask) begin
          prdata[ioxc_pkg::EV_W-1:0] <= imask_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transaction engine
  ioxc_smb_engine u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .req(req_reg),
    .busy(eng_busy),
    .rsp(rsp),
    .bit_clk(bit_clk),
    .sda_i(sda_i),
    .sda_oe_n(sda_oe_n),
    .scl_oe_n(scl_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_test_override: assert property (
    tm_reg && sel_slot[2] |-> want[sel_slot[1:0]] == test_data_reg)
    else $error("test data not used");
  chk_reserved_sel: assert property (
    !sel_slot[2] |-> !set_done)
    else $error("done on reserved select");
  chk_done_sticky: assert property (
    done_reg && !(wr_fire && hit_ctl && pwdata[ioxc_pkg::DONE_BIT])
    |=> done_reg)
    else $error("done lost without clear");
  chk_done_sets: assert property (
    set_done |=> done_reg)
    else $error("done not set");
  chk_test_send: assert property (
    wr_fire && hit_ctl && pwdata[ioxc_pkg::TM_BIT] &&
    sel2slot(pwdata[ioxc_pkg::SEL_LSB +: 4]) != 3'b000 && !req_reg.start
    |=> pend_out_reg != 4'h0)
    else $error("test write not queued");
  chk_init_queued: assert property (
    wr_fire && hit_addr |=> pend_init_reg[2:0] == 3'b111)
    else $error("init not queued");
  chk_addr_hold: assert property (
    !(wr_fire && hit_addr) |=> $stable(ea_reg[0]))
    else $error("address changed unwritten");
  chk_rfr_zero: assert property (
    pready && !pwrite && hit_ctl |-> !prdata[ioxc_pkg::RFR_BIT])
    else $error("refresh bit read nonzero");
  chk_rsvd_zero: assert property (
    pready && hit_addr |-> prdata[0] == 1'b0 && prdata[31:24] == 8'h00)
    else $error("reserved bit nonzero");
  chk_irq_level: assert property (
    ##1 irq == |($past(istat_reg) & $past(imask_reg)))
    else $error("irq mismatch");

  cov_refresh: cover property (ev[ioxc_pkg::EV_RFR]);
  cov_init_done: cover property (ev[ioxc_pkg::EV_INIT] && set_done);
  cov_test_done: cover property (set_done &&
    cur_kind_reg == ioxc_pkg::K_OUT);
endmodule : ioxc_top

/* rtl/ioxc_pkg.sv */
package ioxc_pkg;
  // APB byte offsets
  localparam logic [11:0] CTL_OFS = 12'h350; // Interface control
  localparam logic [11:0] ADDR0_OFS = 12'h354; // Expander bus addresses
  localparam logic [11:0] ISTAT_OFS = 12'h370; // Event status
  localparam logic [11:0] IMASK_OFS = 12'h374; // Event mask
  // Control register fields
  localparam int DATA_LSB = 0; // Pin values, 16 bits
  localparam int RFR_BIT = 24; // Refresh request
  localparam int TM_BIT = 25; // Test mode
  localparam int SEL_LSB = 26; // Select, 4 bits
  localparam int DONE_BIT = 31; // Completion flag
  // Address register fields
  localparam int ADDR0_LSB = 1;
  localparam int ADDR1_LSB = 9;
  localparam int ADDR2_LSB = 17;
  // Select codes
  localparam logic [3:0] SEL_E0 = 4'h0;
  localparam logic [3:0] SEL_E1 = 4'h1;
  localparam logic [3:0] SEL_E2 = 4'h2;
  localparam logic [3:0] SEL_E4 = 4'h4;
  // Slot 3 stands for expander four
  localparam logic [1:0] SLOT_E4 = 2'h3;
  // Pins that are expander inputs, read-only
  localparam logic [15:0] INPUT_MASK = 16'hFF00;
  // Bus address of expander four, arbitrary value
  localparam logic [6:0] E4_ADDR = 7'h20;
  // Event status bits
  localparam int EV_DONE = 0; // Selected operation done
  localparam int EV_INIT = 1; // Any init sequence done
  localparam int EV_RFR = 2; // Any refresh done
  localparam int EV_W = 3;
  // Frame: 8 address bits then 16 data bits
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] ADDR_BITS = 5'h08;
  // Transaction kinds
  typedef enum logic [1:0] {
    K_INIT = 2'b00,
    K_OUT = 2'b01,
    K_RFR = 2'b10
  } ioxc_kind_t;
  // Engine request
  typedef struct packed {
    logic start;
    ioxc_kind_t kind;
    logic [6:0] addr;
    logic [15:0] wdata;
  } ioxc_req_t;
  // Engine answer
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } ioxc_rsp_t;
endpackage : ioxc_pkg

/* rtl/ioxc_smb_engine.sv */
`timescale 1ns/1ns
module ioxc_smb_engine (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input ioxc_pkg::ioxc_req_t req, // Transaction request
  output logic busy, // Frame in progress
  output ioxc_pkg::ioxc_rsp_t rsp, // Completion and read data
  input wire logic bit_clk, // Link bit clock
  input wire logic sda_i, // Data line level
  output logic sda_oe_n, // Data pull-down, low drives
  output logic scl_oe_n // Clock pull-down, low drives
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01
  } ioxc_est_t;

  ioxc_est_t state_reg; // Frame state
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg; // Bit clock sync
  logic sda_s1_reg, sda_s2_reg; // Data line sync
  logic [4:0] cnt_reg; // Bit index
  logic [23:0] frame_reg; // Bits to send
  logic [23:0] drv_reg; // Which bits are driven
  logic rise, fall;

  assign rise = clk_s2_reg & ~clk_s3_reg;
  assign fall = ~clk_s2_reg & clk_s3_reg;
  assign busy = (state_reg == ST_SHIFT);

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      clk_s1_reg <= bit_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter: drive on falling, sample on rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      frame_reg <= 24'h000000;
      drv_reg <= 24'h000000;
      rsp <= '0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
    end else begin
      rsp.done <= 1'b0;
      scl_oe_n <= ~(busy & ~clk_s2_reg);
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
          if (req.start) begin
            // Address, read flag, then data
            frame_reg <= {req.addr, req.kind == ioxc_pkg::K_RFR,
                          req.wdata};
            drv_reg <= {8'hFF, (req.kind == ioxc_pkg::K_RFR) ?
                        ~ioxc_pkg::INPUT_MASK : 16'hFFFF};
            // First address bit stands before the first rising edge
            sda_oe_n <= req.addr[$high(req.addr)];
            cnt_reg <= 5'h00;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (fall) begin
            sda_oe_n <= ~(drv_reg[23] & ~frame_reg[23]);
          end
          if (rise) begin
            if (cnt_reg >= ioxc_pkg::ADDR_BITS) begin
              rsp.rdata <= {rsp.rdata[14:0], sda_s2_reg};
            end
            frame_reg <= {frame_reg[22:0], 1'b0};
            drv_reg <= {drv_reg[22:0], 1'b0};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == ioxc_pkg::FRAME_LAST) begin
              rsp.done <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_done_after_frame: assert property (@(posedge pclk)
    disable iff (!presetn) rsp.done |-> $past(busy) && !busy)
    else $error("done without a frame");
  chk_idle_release: assert property (@(posedge pclk)
    disable iff (!presetn) !busy ##1 !busy |-> sda_oe_n)
    else $error("data line held while idle");
endmodule : ioxc_smb_engine

/* sim/ioxc_expander_model.sv */
`timescale 1ns/1ns
module ioxc_expander_model #(
  parameter logic [15:0] PIN_IN = 16'hA55A // Input pin levels shown
) (
  input wire logic go, // Bench lets the bit clock run
  input wire logic sda, // Data line as seen on the wire
  output logic bit_clk, // Link bit clock, 320 ns
  output logic pull // High pulls the data line low
);
  int cnt = 0; // Rising edges seen in this frame
  logic rd_flag = 1'b0; // Frame asks for pin values
  //////////////////////////////////////////////////////////////////////
  // Bit clock stands still while no traffic is allowed
  initial begin
    bit_clk = 1'b0;
    forever begin
      if (go) #160 bit_clk = ~bit_clk;
      else begin
        bit_clk = 1'b0;
        #40;
      end
    end
  end
  // Count bits of a frame and note the read flag
  always @(posedge bit_clk or negedge go) begin
    if (!go) cnt <= 0;
    else begin
      if (cnt == 7) rd_flag <= sda;
      cnt <= (cnt == 23) ? 0 : cnt + 1;
    end
  end
  // Pull low for zero input bits on a read, MSB first
  always @(negedge bit_clk or negedge go) begin
    if (!go) pull <= 1'b0;
    else pull <= rd_flag && cnt >= 8 && ioxc_pkg::INPUT_MASK[23-cnt]
      && !PIN_IN[23-cnt];
  end
endmodule : ioxc_expander_model

/* sim/ioxc_top_bench.sv */
`timescale 1ns/1ns
module ioxc_top_bench;
  logic pclk = 0, presetn = 0, cold_rst_n = 0, go = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sda_oe_n, scl_oe_n, irq, bit_clk, pull;
  logic [3:0][15:0] core_out = {16'h0, 16'h0, 16'h0, 16'h00C3};
  wire sda_i = sda_oe_n & ~pull; // Open drain with pull-up
  int failures = 0, n_compared = 0;
  //////////////////////////////////////////////////////////////////////
  ioxc_top dut (.pclk(pclk), .presetn(presetn), .cold_rst_n(cold_rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_out(core_out), .bit_clk(bit_clk), .sda_i(sda_i),
    .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n), .irq(irq));
  ioxc_expander_model exp_m (.go(go), .sda(sda_i), .bit_clk(bit_clk),
    .pull(pull));
  // System clock, 40 ns
  initial begin
    forever #20 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Compare the masked bits of a result
  task chk(input logic [31:0] got, input logic [31:0] ex,
    input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (ex & m)) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : chk
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  // Poll the done flag, then let the link settle
  task wait_done;
    int n;
    go <= 1;
    n = 0;
    do begin
      apb(0, 12'h350, 32'h0);
      n++;
    end while (rd[31] !== 1'b1 && n < 400);
    chk(rd, 32'h80000000, 32'h80000000); // done reached
    repeat (1000) @(posedge pclk);
    go <= 0;
  endtask : wait_done
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1; cold_rst_n <= 1;
    // Pins show the core's values for expander zero
    apb(0, 12'h350, 0); chk(rd, 32'hC3, 32'hFFFFFFFF); // reset value, pins C3
    apb(0, 12'h354, 0); chk(rd, 0, 32'hFFFFFFFF); // reset zero
    $display("test reset done");
    apb(1, 12'h374, 32'h1);
    apb(1, 12'h354, 32'hFFFFFFFF);
    apb(0, 12'h354, 0); chk(rd, 32'h00FEFEFE, 32'hFFFFFFFF);
    wait_done(); // init done
    chk({31'h0, irq}, 1, 1); // event raises irq
    apb(0, 12'h370, 0); chk(rd, 1, 1); // status set
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0, 1); // read clears irq
    apb(1, 12'h350, 32'h80000000);
    apb(0, 12'h350, 0); chk(rd, 0, 32'h80000000); // W1C
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h354, 0); chk(rd, 32'h00FEFEFE, 32'hFFFFFFFF);
    $display("test addresses done");
    apb(1, 12'h350, 32'h02001234);
    wait_done(); // test mode send
    apb(0, 12'h350, 0); chk(rd, 32'h34, 32'hFF); // sw data
    apb(1, 12'h350, 32'h83001234);
    apb(0, 12'h350, 0); chk(rd, 0, 32'h01000000); // reads zero
    wait_done(); // refresh done
    apb(0, 12'h350, 0); chk(rd, 32'hA534, 32'hFFFF); // pins
    $display("test pins done");
    for (int s = 1; s < 8; s++) begin
      apb(1, 12'h350, 32'h81000000 | (s << 26));
      if (s == 1 || s == 2 || s == 4) wait_done(); // codes
      else begin
        go <= 1;
        repeat (1500) @(posedge pclk);
        go <= 0;
        apb(0, 12'h350, 0); chk(rd, 0, 32'h8000FFFF); // reserved
      end
    end
    apb(0, 12'h360, 0); chk({err, rd[30:0]}, 32'h80000000, 32'hFFFFFFFF);
    $display("test select done");
    give_verdict();
  end
endmodule : ioxc_top_bench
